// ---- mbact_pkg.sv ----
package mbact_pkg;
    // protocol data addresses of the flat table
    localparam logic [15:0] ADR_SETPOINT = 16'h0000;
    localparam logic [15:0] ADR_FORCE = 16'h0001;
    localparam logic [15:0] ADR_SERVICE = 16'h0002;
    localparam logic [15:0] ADR_CATEGORY = 16'h0003;
    localparam logic [15:0] ADR_POS_PCT = 16'h0004;
    localparam logic [15:0] ADR_POS_ABS = 16'h0005;
    localparam logic [15:0] ADR_FLOW_PCT = 16'h0006;
    localparam logic [15:0] ADR_FLOW_ABS = 16'h0007;
    localparam logic [15:0] ADR_SENSOR = 16'h0008;
    localparam logic [15:0] ADR_SERIAL1 = 16'h0064;
    localparam logic [15:0] ADR_SERIAL2 = 16'h0065;
    localparam logic [15:0] ADR_SERIAL4 = 16'h0066;
    localparam logic [15:0] ADR_VERSION = 16'h0067;
    localparam logic [15:0] ADR_FLAGS = 16'h0068;
    localparam logic [15:0] ADR_LOWER = 16'h0069;
    localparam logic [15:0] ADR_UPPER = 16'h006a;
    localparam logic [15:0] ADR_SKIND = 16'h006b;
    localparam logic [15:0] ADR_LOSS = 16'h006c;
    // bit address of the flags word for discrete-input reads
    localparam logic [15:0] ADR_FLAGS_BITS = 16'h0680;
    // function codes
    localparam logic [7:0] FC_READ_DISC = 8'h02;
    localparam logic [7:0] FC_READ_HOLD = 8'h03;
    localparam logic [7:0] FC_READ_INP = 8'h04;
    localparam logic [7:0] FC_WRITE_ONE = 8'h06;
    localparam logic [7:0] FC_WRITE_MANY = 8'h10;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
    // forced position values
    localparam logic [15:0] FORCE_NONE = 16'h0000;
    localparam logic [15:0] FORCE_OPEN = 16'h0001;
    localparam logic [15:0] FORCE_CLOSE = 16'h0002;
    localparam logic [15:0] FORCE_MIN = 16'h0003;
    localparam logic [15:0] FORCE_MAX = 16'h0005;
    // link loss actions
    localparam logic [15:0] LOSS_HOLD = 16'h0000;
    localparam logic [15:0] LOSS_CLOSE = 16'h0001;
    localparam logic [15:0] LOSS_OPEN = 16'h0002;
    // position scale, hundredths of a percent
    localparam logic [15:0] POS_FULL = 16'h2710;
    localparam logic [15:0] POS_ZERO = 16'h0000;
    localparam logic [15:0] NOT_SUPPORTED = 16'hffff;
    // factory defaults of communication parameters
    localparam logic [7:0] DEF_BASE_ADDR = 8'h00;
    localparam logic [2:0] DEF_BAUD_SEL = 3'h2;
    localparam logic [4:0] QUICK_MAX = 5'h10;
    localparam logic [4:0] QUICK_MIN = 5'h01;
    // flag bit positions
    localparam int FLAG_ACTIVITY = 8;
    localparam int FLAG_GEAR = 9;
    localparam int FLAG_WATCHDOG = 10;
    localparam logic [15:0] SVC_CLEAR_FAULTS = 16'h0004;
    localparam logic [15:0] FAULT_KEEP = 16'h0011;
    // link watchdog time
    localparam longint CLK_HZ = 200000000;
    localparam longint LOSS_TIME_S = 120;
    localparam longint LOSS_CYCLES = LOSS_TIME_S * CLK_HZ;
    // non-volatile defaults
    localparam logic [15:0] DEF_LOWER = 16'h0000;
    localparam logic [15:0] DEF_UPPER = 16'h2710;
endpackage

// ---- mbact_req_if.sv ----
`timescale 1ns/1ps
// one decoded table access between front end and table
interface mbact_req_if;
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic hit;
    logic writable;
    modport table_side (input wr, rd, addr, wdata, output rdata, hit, writable);
    modport user_side (output wr, rd, addr, wdata, input rdata, hit, writable);
endinterface

// ---- mbact_table.sv ----
`timescale 1ns/1ps
// flat word table shared by every object type
module mbact_table (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // access port
    mbact_req_if.table_side acc,
    // live values
    input wire logic [15:0] pos_now,
    input wire logic [15:0] flags_now,
    input wire logic [15:0] sensor_now,
    input wire logic [15:0] category_now,
    input wire logic svc_taken,
    // stored controls
    output logic [15:0] setpoint_q,
    output logic [15:0] force_q,
    output logic [15:0] service_q,
    output logic [15:0] lower_q,
    output logic [15:0] upper_q,
    output logic [15:0] skind_q,
    output logic [15:0] loss_q,
    output logic nv_write
);
    parameter logic [15:0] SERIAL_ONE = 16'h0001; // arbitrary value
    parameter logic [15:0] SERIAL_TWO = 16'h0002; // arbitrary value
    parameter logic [15:0] SERIAL_FOUR = 16'h0003; // arbitrary value
    parameter logic [15:0] VERSION = 16'h0064; // arbitrary value
    logic [15:0] setpoint_d, force_d, service_d, lower_d, upper_d, skind_d, loss_d;
    logic nv_d;

    // read mux and hit decode, one map for all object types
    always_comb begin
        acc.rdata = 16'h0000;
        acc.hit = 1'b1;
        acc.writable = 1'b0;
        case (acc.addr)
            mbact_pkg::ADR_SETPOINT: begin acc.rdata = setpoint_q; acc.writable = 1'b1; end
            mbact_pkg::ADR_FORCE: begin acc.rdata = force_q; acc.writable = 1'b1; end
            mbact_pkg::ADR_SERVICE: begin acc.rdata = service_q; acc.writable = 1'b1; end
            mbact_pkg::ADR_CATEGORY: acc.rdata = category_now;
            mbact_pkg::ADR_POS_PCT: acc.rdata = pos_now;
            mbact_pkg::ADR_POS_ABS: acc.rdata = pos_now;
            mbact_pkg::ADR_FLOW_PCT: acc.rdata = mbact_pkg::NOT_SUPPORTED;
            mbact_pkg::ADR_FLOW_ABS: acc.rdata = mbact_pkg::NOT_SUPPORTED;
            mbact_pkg::ADR_SENSOR: acc.rdata = sensor_now;
            mbact_pkg::ADR_SERIAL1: acc.rdata = SERIAL_ONE;
            mbact_pkg::ADR_SERIAL2: acc.rdata = SERIAL_TWO;
            mbact_pkg::ADR_SERIAL4: acc.rdata = SERIAL_FOUR;
            mbact_pkg::ADR_VERSION: acc.rdata = VERSION;
            mbact_pkg::ADR_FLAGS: acc.rdata = flags_now;
            mbact_pkg::ADR_LOWER: begin acc.rdata = lower_q; acc.writable = 1'b1; end
            mbact_pkg::ADR_UPPER: begin acc.rdata = upper_q; acc.writable = 1'b1; end
            mbact_pkg::ADR_SKIND: begin acc.rdata = skind_q; acc.writable = 1'b1; end
            mbact_pkg::ADR_LOSS: begin acc.rdata = loss_q; acc.writable = 1'b1; end
            default: acc.hit = 1'b0;
        endcase
    end

    // write decode; service word self-clears once taken
    always_comb begin
        setpoint_d = setpoint_q;
        force_d = force_q;
        service_d = svc_taken ? 16'h0000 : service_q;
        lower_d = lower_q;
        upper_d = upper_q;
        skind_d = skind_q;
        loss_d = loss_q;
        nv_d = 1'b0;
        if (acc.wr) begin
            case (acc.addr)
                mbact_pkg::ADR_SETPOINT: setpoint_d = acc.wdata;
                mbact_pkg::ADR_FORCE: force_d = acc.wdata;
                mbact_pkg::ADR_SERVICE: service_d = acc.wdata; // new request wins over clear
                mbact_pkg::ADR_LOWER: begin lower_d = acc.wdata; nv_d = 1'b1; end
                mbact_pkg::ADR_UPPER: begin upper_d = acc.wdata; nv_d = 1'b1; end
                mbact_pkg::ADR_SKIND: begin skind_d = acc.wdata; nv_d = 1'b1; end
                mbact_pkg::ADR_LOSS: begin loss_d = acc.wdata; nv_d = 1'b1; end
                default: ;
            endcase
        end
    end

    // volatile group clears, non-volatile group reloads its defaults on reset as well
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            setpoint_q <= 16'h0000;
            force_q <= 16'h0000;
            service_q <= 16'h0000;
            lower_q <= mbact_pkg::DEF_LOWER;
            upper_q <= mbact_pkg::DEF_UPPER;
            skind_q <= 16'h0000;
            loss_q <= mbact_pkg::LOSS_HOLD;
            nv_write <= 1'b0;
        end else begin
            setpoint_q <= setpoint_d;
            force_q <= force_d;
            service_q <= service_d;
            lower_q <= lower_d;
            upper_q <= upper_d;
            skind_q <= skind_d;
            loss_q <= loss_d;
            nv_write <= nv_d;
        end
    end
endmodule

// ---- mbact_motion.sv ----
`timescale 1ns/1ps
// drive sequencer: homing, end-stop stop, gear release
module mbact_motion (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // targets and sensing
    input wire logic [15:0] target,
    input wire logic [15:0] pos_now,
    input wire logic end_stop,
    input wire logic manual_btn,
    // drive
    output logic drive_en,
    output logic drive_dir,
    output logic gear_free,
    output logic homing
);
    typedef enum logic [1:0] {MBACT_HOME = 2'b00, MBACT_TRACK = 2'b01, MBACT_FREE = 2'b11} mbact_mst_t;
    mbact_mst_t st_q, st_d;
    logic en_d, dir_d;

    // next state: home first, then follow the target
    always_comb begin
        st_d = st_q;
        en_d = 1'b0;
        dir_d = 1'b0;
        case (st_q)
            MBACT_HOME: begin
                en_d = !end_stop;
                dir_d = 1'b0;
                if (manual_btn) st_d = MBACT_FREE;
                else if (end_stop) st_d = MBACT_TRACK;
            end
            MBACT_TRACK: begin
                dir_d = target > pos_now;
                // a hard stop ends travel without any limit switch
                en_d = (target != pos_now) && !end_stop;
                if (manual_btn) st_d = MBACT_FREE;
            end
            MBACT_FREE: begin
                if (!manual_btn) st_d = MBACT_HOME;
            end
            default: st_d = MBACT_HOME;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_q <= MBACT_HOME;
            drive_en <= 1'b0;
            drive_dir <= 1'b0;
            gear_free <= 1'b0;
            homing <= 1'b1;
        end else begin
            st_q <= st_d;
            drive_en <= en_d;
            drive_dir <= dir_d;
            gear_free <= (st_d == MBACT_FREE);
            homing <= (st_d == MBACT_HOME);
        end
    end
endmodule

// ---- mbact_regmap.sv ----
`timescale 1ns/1ps
module mbact_regmap #(
    parameter longint LOSS_CYCLES = mbact_pkg::LOSS_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // decoded request frame from the link layer
    input wire logic req_valid,
    input wire logic [7:0] req_node,
    input wire logic [7:0] req_func,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_count,
    input wire logic [15:0] req_wdata,
    input wire logic req_wnext,
    // answer word stream to the link layer
    output logic rsp_valid,
    output logic [7:0] rsp_func,
    output logic [7:0] rsp_exc,
    output logic [15:0] rsp_data,
    output logic rsp_last,
    output logic req_wtake,
    // quick addressing and power-up buttons
    input wire logic [4:0] quick_sel,
    input wire logic [7:0] base_addr,
    input wire logic [2:0] baud_sel,
    input wire logic btn3,
    output logic [7:0] node_addr,
    output logic comm_default,
    // actuator side
    input wire logic [15:0] pos_now,
    input wire logic [15:0] sensor_now,
    input wire logic [15:0] category_now,
    input wire logic [7:0] fault_now,
    input wire logic end_stop,
    input wire logic manual_btn,
    input wire logic svc_taken,
    output logic drive_en,
    output logic drive_dir,
    output logic gear_free,
    output logic [15:0] target_pos,
    output logic [15:0] service_cmd,
    output logic nv_write
);
    typedef enum logic [2:0] {
        MBACT_IDLE = 3'b000, MBACT_READ = 3'b001, MBACT_WRITE = 3'b011, MBACT_ACK = 3'b010, MBACT_EXC = 3'b110
    } mbact_st_t;

    mbact_req_if acc ();
    logic [15:0] setpoint_q, force_q, service_q, lower_q, upper_q, skind_q, loss_q;
    logic nv_w, homing, drv_en, drv_dir, gear_w;
    mbact_st_t st_q, st_d;
    logic [15:0] addr_q, addr_d, left_q, left_d;
    logic [7:0] func_q, func_d, exc_q, exc_d;
    logic rsp_valid_d, rsp_last_d, wtake_d;
    logic [15:0] rsp_data_d;
    logic first_q, comm_def_q, comm_def_d;
    logic [7:0] node_q, node_d;
    logic [35:0] wd_q, wd_d; // two minutes at full rate overflow 32 bits
    logic wd_fired_q, wd_fired_d;
    logic [15:0] flags_w, tgt_q, tgt_d, fault_q, fault_d;

    // range check over the whole requested span
    function automatic logic span_ok(input logic [15:0] a, input logic [15:0] n);
        logic [16:0] e;
        e = {1'b0, a} + {1'b0, n} - 17'h0_0001;
        span_ok = (n != 16'h0000) && ((e[15:0] <= mbact_pkg::ADR_SENSOR && !e[16])
            || (a >= mbact_pkg::ADR_SERIAL1 && e[15:0] <= mbact_pkg::ADR_LOSS && !e[16]));
    endfunction

    function automatic logic fc_known(input logic [7:0] f);
        fc_known = (f == mbact_pkg::FC_READ_HOLD) || (f == mbact_pkg::FC_WRITE_ONE)
            || (f == mbact_pkg::FC_READ_DISC) || (f == mbact_pkg::FC_READ_INP)
            || (f == mbact_pkg::FC_WRITE_MANY);
    endfunction

    // flags word: live bits on top of sticky fault byte
    assign flags_w = {5'h00, wd_fired_q, gear_w, (homing || service_q != 16'h0000), fault_q[7:0]};

    mbact_table u_table (
        .core_clk(core_clk), .rst_n(rst_n), .acc(acc.table_side),
        .pos_now(pos_now), .flags_now(flags_w), .sensor_now(sensor_now),
        .category_now(category_now), .svc_taken(svc_taken),
        .setpoint_q(setpoint_q), .force_q(force_q), .service_q(service_q),
        .lower_q(lower_q), .upper_q(upper_q), .skind_q(skind_q), .loss_q(loss_q),
        .nv_write(nv_w)
    );

    mbact_motion u_motion (
        .core_clk(core_clk), .rst_n(rst_n), .target(tgt_q), .pos_now(pos_now),
        .end_stop(end_stop), .manual_btn(manual_btn),
        .drive_en(drv_en), .drive_dir(drv_dir), .gear_free(gear_w), .homing(homing)
    );

    // table port driven from the protocol walker
    assign acc.addr = addr_q;
    assign acc.rd = (st_q == MBACT_READ);
    assign acc.wr = (st_q == MBACT_WRITE) && req_wnext && acc.writable;
    assign acc.wdata = req_wdata;

    // protocol walker: one word per cycle
    always_comb begin
        st_d = st_q;
        addr_d = addr_q;
        left_d = left_q;
        func_d = func_q;
        exc_d = exc_q;
        rsp_valid_d = 1'b0;
        rsp_last_d = 1'b0;
        rsp_data_d = 16'h0000;
        wtake_d = 1'b0;
        case (st_q)
            MBACT_IDLE: begin
                if (req_valid && req_node == node_q) begin
                    func_d = req_func;
                    left_d = (req_func == mbact_pkg::FC_WRITE_ONE) ? 16'h0001 : req_count;
                    addr_d = req_addr;
                    // discrete reads reach the flags word through its bit address
                    if (req_func == mbact_pkg::FC_READ_DISC && req_addr == mbact_pkg::ADR_FLAGS_BITS) begin
                        addr_d = mbact_pkg::ADR_FLAGS;
                        left_d = 16'h0001;
                    end
                    if (!fc_known(req_func)) begin
                        exc_d = mbact_pkg::EXC_ILL_FUNC;
                        st_d = MBACT_EXC;
                    end else if (!span_ok(addr_d, left_d)) begin
                        exc_d = mbact_pkg::EXC_ILL_ADDR;
                        st_d = MBACT_EXC;
                    end else if (req_func == mbact_pkg::FC_WRITE_ONE || req_func == mbact_pkg::FC_WRITE_MANY) begin
                        st_d = MBACT_WRITE;
                    end else begin
                        st_d = MBACT_READ;
                    end
                end
            end
            MBACT_READ: begin
                rsp_valid_d = 1'b1;
                rsp_data_d = acc.rdata;
                left_d = left_q - 16'h0001;
                addr_d = addr_q + 16'h0001;
                if (left_q == 16'h0001) begin
                    rsp_last_d = 1'b1;
                    st_d = MBACT_IDLE;
                end
            end
            MBACT_WRITE: begin
                if (req_wnext) begin
                    wtake_d = 1'b1;
                    left_d = left_q - 16'h0001;
                    addr_d = addr_q + 16'h0001;
                    if (left_q == 16'h0001) st_d = MBACT_ACK;
                end
            end
            MBACT_ACK: begin
                rsp_valid_d = 1'b1;
                rsp_last_d = 1'b1;
                rsp_data_d = req_addr;
                st_d = MBACT_IDLE;
            end
            MBACT_EXC: begin
                rsp_valid_d = 1'b1;
                rsp_last_d = 1'b1;
                st_d = MBACT_IDLE;
            end
            default: st_d = MBACT_IDLE;
        endcase
    end

    // node address, power-up default catch, watchdog, target choice
    always_comb begin
        node_d = base_addr + {3'h0, quick_sel};
        if (quick_sel < mbact_pkg::QUICK_MIN || quick_sel > mbact_pkg::QUICK_MAX) node_d = base_addr;
        comm_def_d = comm_def_q;
        if (first_q) comm_def_d = btn3;
        if (comm_def_q) node_d = mbact_pkg::DEF_BASE_ADDR;
        // refresh of setpoint or override restarts the count
        wd_d = wd_q;
        wd_fired_d = wd_fired_q;
        if (acc.wr && (addr_q == mbact_pkg::ADR_SETPOINT || addr_q == mbact_pkg::ADR_FORCE)) begin
            wd_d = 36'h0_0000_0000;
            wd_fired_d = 1'b0;
        end else if (loss_q == mbact_pkg::LOSS_HOLD) begin
            wd_d = 36'h0_0000_0000;
            wd_fired_d = 1'b0;
        end else if (wd_q >= 36'(LOSS_CYCLES - 1)) begin
            wd_fired_d = 1'b1;
        end else begin
            wd_d = wd_q + 36'h0_0000_0001;
        end
        // limits bound the setpoint; override then replaces it, open and close unbounded
        tgt_d = setpoint_q > mbact_pkg::POS_FULL ? mbact_pkg::POS_FULL : setpoint_q;
        if (tgt_d < lower_q) tgt_d = lower_q;
        if (tgt_d > upper_q) tgt_d = upper_q;
        case (force_q)
            mbact_pkg::FORCE_OPEN: tgt_d = mbact_pkg::POS_FULL;
            mbact_pkg::FORCE_CLOSE: tgt_d = mbact_pkg::POS_ZERO;
            mbact_pkg::FORCE_MIN: tgt_d = lower_q;
            mbact_pkg::FORCE_MAX: tgt_d = upper_q;
            default: ;
        endcase
        if (wd_fired_q) tgt_d = (loss_q == mbact_pkg::LOSS_OPEN) ? mbact_pkg::POS_FULL : mbact_pkg::POS_ZERO;
        // fault bits sticky; clear command spares the two permanent ones
        fault_d = fault_q | {8'h00, fault_now};
        if (svc_taken && service_q == mbact_pkg::SVC_CLEAR_FAULTS)
            fault_d = (fault_q & mbact_pkg::FAULT_KEEP) | {8'h00, fault_now};
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_q <= MBACT_IDLE;
            addr_q <= 16'h0000;
            left_q <= 16'h0000;
            func_q <= 8'h00;
            exc_q <= 8'h00;
            first_q <= 1'b1;
            comm_def_q <= 1'b0;
            node_q <= mbact_pkg::DEF_BASE_ADDR;
            wd_q <= 36'h0_0000_0000;
            wd_fired_q <= 1'b0;
            tgt_q <= mbact_pkg::POS_ZERO;
            fault_q <= 16'h0000;
            rsp_valid <= 1'b0;
            rsp_func <= 8'h00;
            rsp_exc <= 8'h00;
            rsp_data <= 16'h0000;
            rsp_last <= 1'b0;
            req_wtake <= 1'b0;
            node_addr <= mbact_pkg::DEF_BASE_ADDR;
            comm_default <= 1'b0;
            drive_en <= 1'b0;
            drive_dir <= 1'b0;
            gear_free <= 1'b0;
            target_pos <= mbact_pkg::POS_ZERO;
            service_cmd <= 16'h0000;
            nv_write <= 1'b0;
        end else begin
            st_q <= st_d;
            addr_q <= addr_d;
            left_q <= left_d;
            func_q <= func_d;
            exc_q <= exc_d;
            first_q <= 1'b0;
            comm_def_q <= comm_def_d;
            node_q <= node_d;
            wd_q <= wd_d;
            wd_fired_q <= wd_fired_d;
            tgt_q <= tgt_d;
            fault_q <= fault_d;
            rsp_valid <= rsp_valid_d;
            rsp_func <= (st_q == MBACT_EXC) ? (func_q | mbact_pkg::EXC_FLAG) : func_q;
            rsp_exc <= (st_q == MBACT_EXC) ? exc_q : 8'h00;
            rsp_data <= rsp_data_d;
            rsp_last <= rsp_last_d;
            req_wtake <= wtake_d;
            node_addr <= node_q;
            comm_default <= comm_def_q;
            drive_en <= drv_en;
            drive_dir <= drv_dir;
            gear_free <= gear_w;
            target_pos <= tgt_q;
            service_cmd <= service_q;
            nv_write <= nv_w;
        end
    end
endmodule

// ---- mbact_checker.sv ----
`timescale 1ns/1ps
// watches the register map at its ports
module mbact_checker (
    // watched ports, grouped by width
    input wire logic core_clk, rst_n, req_wnext, rsp_valid, rsp_last, comm_default,
    input wire logic end_stop, manual_btn, svc_taken, drive_en, drive_dir, gear_free,
    input wire logic [7:0] rsp_func, rsp_exc, base_addr, node_addr,
    input wire logic [4:0] quick_sel,
    input wire logic [15:0] service_cmd
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // node address lags its inputs by two cycles
    AST_NODE: assert property ($past(rst_n, 3) && $stable(quick_sel) && $stable(base_addr)
        && quick_sel inside {[1:16]} |=> comm_default || node_addr == base_addr + 8'(quick_sel))
        else $error("node address wrong");
    AST_DEFAULT: assert property (comm_default && $past(comm_default, 2) |-> node_addr == 8'h00)
        else $error("default node wrong");
    AST_EXC: assert property (rsp_valid && rsp_exc != 8'h00 |-> rsp_func[7] && rsp_last)
        else $error("exception frame wrong");
    AST_ILLFN: assert property (rsp_valid && rsp_exc == 8'h01
        |-> !((rsp_func & 8'h7f) inside {8'h02, 8'h03, 8'h04, 8'h06, 8'h10})) else $error("code refused");
    AST_OKFC: assert property (rsp_valid && rsp_exc == 8'h00
        |-> rsp_func inside {8'h02, 8'h03, 8'h04, 8'h06, 8'h10}) else $error("odd code answered");
    AST_GEAR: assert property (manual_btn [*3] |-> gear_free) else $error("gear held");
    // homing drive toward zero must stop at the end stop
    AST_STOP: assert property ($rose(end_stop) && drive_en && !drive_dir
        |-> ##[1:2] (!drive_en || drive_dir)) else $error("drive ran on");
    AST_SVC: assert property (svc_taken && !req_wnext && service_cmd != 16'h0000
        |-> ##[1:2] service_cmd == 16'h0000) else $error("service word kept");
endmodule

// ---- mbact_master.sv ----
`timescale 1ns/1ps
// bus master: one request frame per call
module mbact_master (
    // clock
    input wire logic core_clk,
    // request header and write word
    output logic req_valid, req_wnext,
    output logic [7:0] req_node, req_func,
    output logic [15:0] req_addr, req_count, req_wdata
);
    initial {req_valid, req_wnext, req_node, req_func, req_addr, req_count, req_wdata} = '0;
    // header one cycle, write word the next; address held until the ack
    task automatic send(input logic [7:0] node, func, input logic [15:0] regno, data);
        @(posedge core_clk);
        {req_valid, req_node, req_func, req_count} <= {1'b1, node, func, 16'h0001};
        req_addr <= regno - 16'h0001;
        @(posedge core_clk);
        req_valid <= 1'b0;
        req_wnext <= func == 8'h06 || func == 8'h10;
        req_wdata <= data;
        @(posedge core_clk);
        req_wnext <= 1'b0;
        req_wdata <= ~data; // released word never shows the old value
    endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic core_clk, rst_n, req_valid, req_wnext, rsp_valid, rsp_last, req_wtake, btn3, comm_default;
    logic end_stop, manual_btn, svc_taken, drive_en, drive_dir, gear_free, nv_write;
    logic [7:0] req_node, req_func, rsp_func, rsp_exc, base_addr, node_addr, fault_now;
    logic [15:0] req_addr, req_count, req_wdata, rsp_data, pos_now, sensor_now, category_now;
    logic [15:0] target_pos, service_cmd, sp;
    logic [4:0] quick_sel;
    logic [2:0] baud_sel;
    logic [31:0] seed;
    logic [32:0] e;
    logic [32:0] exp_q[$];
    int errors, checked;
    mbact_regmap #(.LOSS_CYCLES(1000)) u_mbact_regmap (.core_clk, .rst_n, .req_valid, .req_node, .req_func,
        .req_addr, .req_count, .req_wdata, .req_wnext, .rsp_valid, .rsp_func, .rsp_exc, .rsp_data, .rsp_last,
        .req_wtake, .quick_sel, .base_addr, .baud_sel, .btn3, .node_addr, .comm_default, .pos_now, .sensor_now,
        .category_now, .fault_now, .end_stop, .manual_btn, .svc_taken, .drive_en, .drive_dir, .gear_free,
        .target_pos, .service_cmd, .nv_write);
    mbact_master u_mbact_master (.core_clk, .req_valid, .req_wnext, .req_node, .req_func, .req_addr,
        .req_count, .req_wdata);
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [39:0] seen, want);
        checked++;
        if (seen !== want) begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic test_done();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // note: save pulse on non-volatile-group writes, echoed code, exception, word or ack address
    task automatic xfer(input logic [7:0] f, input logic [15:0] r, v, input logic [7:0] x);
        exp_q.push_back({(f == 8'h06 || f == 8'h10) && r > 16'd100, (x != 0) ? (f | 8'h80) : f, x,
            (f == 8'h06 || f == 8'h10) ? r - 16'h1 : v});
        u_mbact_master.send(node_addr, f, r, v);
        for (int n = 0; rsp_last !== 1'b1; n++) begin
            @(posedge core_clk);
            if (n == 20) begin
                errors++;
                test_done();
            end
        end
    endtask
    // answer monitor against the oldest note
    always @(posedge core_clk) begin
        if (rsp_valid === 1'b1) begin
            e = exp_q.pop_front();
            check(40'({nv_write, rsp_func, rsp_exc, rsp_data}), 40'(e));
        end
    end
    initial begin
        seed = 32'd88;
        {rst_n, btn3, end_stop, manual_btn, svc_taken, fault_now, baud_sel} <= 16'h0002;
        {pos_now, sensor_now} <= rnd();
        category_now <= 16'h0001;
        quick_sel <= 5'(rnd() % 16 + 1);
        base_addr <= 8'(rnd() & 32'h7f);
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        end_stop <= 1'b1;
        @(posedge core_clk);
        end_stop <= 1'b0;
        check({32'h0, node_addr}, {32'h0, base_addr + 8'(quick_sel)});
        $display("test addressing done");
        sp = 16'(rnd() % 10001);
        xfer(8'h06, 16'd1, sp, 8'h00);
        xfer(8'h03, 16'd1, sp, 8'h00);
        xfer(8'h04, 16'd1, sp, 8'h00);
        xfer(8'h10, 16'd106, 16'h0100, 8'h00);
        xfer(8'h03, 16'd106, 16'h0100, 8'h00);
        xfer(8'h06, 16'd5, 16'h1234, 8'h00);
        xfer(8'h03, 16'd5, pos_now, 8'h00);
        xfer(8'h02, 16'h0681, 16'h0000, 8'h00);
        for (int i = 0; i < 4; i++)
            xfer(8'h03, 16'd101 + 16'(i), (i == 3) ? 16'h0064 : 16'(i + 1), 8'h00);
        xfer(8'h05, 16'd1, 16'h0, 8'h01);
        xfer(8'h03, 16'd10, 16'h0, 8'h02);
        xfer(8'h03, 16'd110, 16'h0, 8'h02);
        $display("test table done");
        for (int i = 0; i < 4; i++) begin
            xfer(8'h06, 16'd2, 16'(i + 1 + (i == 3)), 8'h00);
            repeat (4) @(posedge core_clk);
            check(40'(target_pos), (i == 1) ? 40'h0 : (i == 2) ? 40'h0100 : 40'h2710);
        end
        xfer(8'h06, 16'd2, 16'h0000, 8'h00);
        xfer(8'h06, 16'd109, 16'h0002, 8'h00);
        xfer(8'h06, 16'd1, 16'h0000, 8'h00);
        repeat (1100) @(posedge core_clk);
        check(40'(target_pos), 40'h2710);
        $display("test forcing done");
        xfer(8'h06, 16'd3, 16'h0004, 8'h00);
        svc_taken <= 1'b1;
        @(posedge core_clk);
        svc_taken <= 1'b0;
        manual_btn <= 1'b1;
        repeat (4) @(posedge core_clk);
        manual_btn <= 1'b0;
        check({service_cmd, 23'h0, gear_free}, 40'h1);
        rst_n <= 1'b0;
        btn3 <= 1'b1;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        check({comm_default, node_addr}, 40'h100);
        $display("test service done");
        test_done();
    end
endmodule
bind mbact_regmap mbact_checker u_mbact_checker (.core_clk, .rst_n, .req_wnext, .rsp_valid, .rsp_last,
    .comm_default, .end_stop, .manual_btn, .svc_taken, .drive_en, .drive_dir, .gear_free, .rsp_func, .rsp_exc,
    .base_addr, .node_addr, .quick_sel, .service_cmd);
